/* tb/ppcfr_host.sv */
// Host model that issues register commands to the bank over AXI4-Lite.
`timescale 1ns/1ns
module ppcfr_host (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // The bus idles with nothing offered.
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Address and data go out together; each is dropped only at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // A read waits for the answer with no assumed latency; the bench timeout ends a hang.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule

/* tb/tb_pse_policing_capdet_fault_regs.sv */
// Self-checking bench for the policing, capacitance and turn-on fault register bank.
`timescale 1ns/1ns
module tb_pse_policing_capdet_fault_regs;
  localparam logic [15:0] PPS = 16'h0020;  // Power product units per half-watt step.
  localparam logic [15:0] TM = 16'h0004;  // Margin above the programmed minimum.
  localparam logic [7:0] A_P2 = {ppcfr_pkg::IDX_POLICE_CH2, 2'b00}, A_P3 = {ppcfr_pkg::IDX_POLICE_CH3, 2'b00};
  localparam logic [7:0] A_P4 = {ppcfr_pkg::IDX_POLICE_CH4, 2'b00}, A_CAP = {ppcfr_pkg::IDX_CAP_ENABLE, 2'b00};
  localparam logic [7:0] A_F = {ppcfr_pkg::IDX_FAULT, 2'b00}, A_FC = {ppcfr_pkg::IDX_FAULT_CLEAR, 2'b00};
  localparam logic [7:0] A_CTL = {ppcfr_pkg::IDX_CHAN_CTRL, 2'b00}, A_DS = {ppcfr_pkg::IDX_DISC_START, 2'b00};
  localparam logic [7:0] A_DD = {ppcfr_pkg::IDX_DISC_DONE, 2'b00};
  localparam logic [2:0][7:0] PA = {A_P4, A_P3, A_P2};  // Policing addresses, channel 2 first.
  localparam logic [3:0][7:0] CLS = {8'h3c, 8'h1f, 8'h0e, 8'h08};  // Class 1 to 4 codes.
  localparam logic [2:0][7:0] PV = {8'h0b, 8'h0d, 8'h0c};  // Port voltages around the trip point.
  localparam int E_OFF = 0, E_RST = 1, E_LOAD = 2, E_SF = 3, E_RES = 4, E_CAP = 5;
  logic            CORE_CLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic            ARVALID, ARREADY, RVALID, RREADY;
  logic [7:0]      AWADDR, ARADDR;
  logic [31:0]     WDATA, RDATA, got;
  logic [3:0]      WSTRB, PORT_OFF, CHAN_RESET, POWER_ON_LOAD, START_FAULT, EN_CHG, ALLOC_DENY;
  logic [3:0]      RES_DET_DONE, RES_DET_VALID, CAP_MEAS_DONE, DET_START, CAP_MEAS_START, RESULT_UPDATE, DISC_DONE;
  logic [1:0]      BRESP, RRESP, rsp;
  logic [2:0][1:0] ASSIGNED_CLASS;
  logic [2:0][7:0] PORT_VOLTAGE, PORT_CURRENT, EFF_LIMIT;
  logic [3:0][1:0] FAULT_CAUSE;
  logic [2:0]      POWER_CUT_FAULT;
  int              n_mismatch, check_count, cyc, n_det, n_cs, n_ru;
  ppcfr_regs #(.POWER_PER_STEP(PPS), .TRIP_MARGIN(TM)) dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .PORT_OFF(PORT_OFF),
    .CHAN_RESET(CHAN_RESET), .POWER_ON_LOAD(POWER_ON_LOAD), .ASSIGNED_CLASS(ASSIGNED_CLASS),
    .PORT_VOLTAGE(PORT_VOLTAGE), .PORT_CURRENT(PORT_CURRENT), .START_FAULT(START_FAULT), .FAULT_CAUSE(FAULT_CAUSE),
    .POWER_ENABLE_CHANGE_EVENT(EN_CHG), .ALLOC_DENY(ALLOC_DENY), .RES_DET_DONE(RES_DET_DONE),
    .RES_DET_VALID(RES_DET_VALID), .CAP_MEAS_DONE(CAP_MEAS_DONE), .EFF_LIMIT(EFF_LIMIT),
    .POWER_CUT_FAULT(POWER_CUT_FAULT), .DET_START(DET_START), .CAP_MEAS_START(CAP_MEAS_START),
    .RESULT_UPDATE(RESULT_UPDATE), .DISCOVERY_DONE(DISC_DONE));
  ppcfr_host host_u (.clk(CORE_CLK), .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY), .wdata(WDATA),
    .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY), .bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
    .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY), .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID),
    .rready(RREADY));
  ////////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock.
  initial begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  // Channel 2 pulses are counted, since a one-cycle strobe is easy to miss by polling.
  always @(posedge CORE_CLK) begin
    n_det += DET_START[1];
    n_cs += CAP_MEAS_START[1];
    n_ru += RESULT_UPDATE[1];
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Read and compare data and response.
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = ppcfr_pkg::RESP_OKAY);
    host_u.rd(a, got, rsp);
    chk(got, e);
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  // Write one byte and compare the response.
  task automatic wc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = ppcfr_pkg::RESP_OKAY);
    host_u.wr(a, {24'h0, d}, rsp);
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  // One-cycle pulse on a channel event input, then time for it to settle.
  task automatic ev(input int k, input logic [3:0] m);
    @(posedge CORE_CLK);
    case (k)
      E_OFF: PORT_OFF <= m;
      E_RST: CHAN_RESET <= m;
      E_LOAD: POWER_ON_LOAD <= m;
      E_SF: START_FAULT <= m;
      E_RES: RES_DET_DONE <= m;
      default: CAP_MEAS_DONE <= m;
    endcase
    @(posedge CORE_CLK);
    {PORT_OFF, CHAN_RESET, POWER_ON_LOAD, START_FAULT, RES_DET_DONE, CAP_MEAS_DONE} <= '0;
    repeat (2) @(posedge CORE_CLK);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    RESET = 1'b1;
    {PORT_OFF, CHAN_RESET, POWER_ON_LOAD, START_FAULT, EN_CHG, ALLOC_DENY, RES_DET_DONE, RES_DET_VALID} = '0;
    {CAP_MEAS_DONE, ASSIGNED_CLASS, PORT_VOLTAGE, PORT_CURRENT, FAULT_CAUSE} = '0;
    repeat (8) @(posedge CORE_CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 3; i++) rc(PA[i], 32'hff);
    rc(A_F, 32'h0);
    wc(A_CAP, 8'hff);
    rc(A_CAP, 32'h55);
    wc(8'h98, 8'h12, ppcfr_pkg::RESP_SLVERR);
    rc(8'h98, 32'h0, ppcfr_pkg::RESP_SLVERR);
    // A code under the floor reads back as written but acts as the floor.
    wc(A_P2, 8'h02);
    wc(A_P3, 8'h10);
    repeat (3) @(posedge CORE_CLK);
    chk({8'h0, EFF_LIMIT}, 32'h00ff1004);
    rc(A_P2, 32'h02);
    // Same current, voltage moves the product across the trip point.
    for (int i = 0; i < 3; i++) begin
      PORT_VOLTAGE[1] <= PV[i];
      PORT_CURRENT[1] <= 8'h2b;
      repeat (3) @(posedge CORE_CLK);
      chk({31'h0, POWER_CUT_FAULT[1]}, {31'h0, PV[i] * 8'h2b > 16 * PPS + TM});
    end
    for (int c = 0; c < 4; c++) begin
      ASSIGNED_CLASS[1] <= 2'(c);
      ev(E_LOAD, 4'h4);
      rc(A_P3, {24'h0, CLS[c]});
      ev(E_OFF, 4'h4);
      rc(A_P3, 32'hff);
    end
    wc(A_CTL, 8'h04);
    wc(A_P3, 8'h21);
    ev(E_LOAD, 4'h4);
    rc(A_P3, 32'h21);
    ev(E_RST, 4'h4);
    rc(A_P3, 32'hff);
    rc(A_P2, 32'h02);
    // Channel 3 is denied power and channel 4 has its enable change flagged.
    FAULT_CAUSE <= {2'h1, 2'h1, 2'h2, 2'h1};
    EN_CHG <= 4'h8;
    ALLOC_DENY <= 4'h4;
    ev(E_SF, 4'hf);
    rc(A_F, 32'h39);
    rc(A_F, 32'h39);
    rc(A_FC, 32'h39);
    rc(A_F, 32'h0);
    ev(E_SF, 4'hf);
    ev(E_OFF, 4'h2);
    rc(A_F, 32'h31);
    ev(E_RST, 4'h1);
    rc(A_F, 32'h30);
    // Channel 2 discovery: capacitance step, then a valid signature, then diagnostic mode off.
    wc(A_CTL, 8'h20);
    wc(A_CAP, 8'h04);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) wc(A_CTL, 8'h00);
      RES_DET_VALID <= {2'b00, k == 1, 1'b0};
      wc(A_DS, 8'h02);
      ev(E_RES, 4'h2);
      ev(E_CAP, 4'h2);
      chk(n_det, k + 1);
      chk(n_cs, 1);
      chk(n_ru, 1);
      chk({28'h0, DISC_DONE}, 32'h2);
      wc(A_DD, 8'h02);
      rc(A_DD, 32'h0);
    end
    conclude();
  end
endmodule

/* verilog/ppcfr_pkg.sv */
// Constants, field codes and the state record of the policing, capacitance and turn-on fault register bank.
package ppcfr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; the AXI byte address of each register is four times its index.
  localparam logic [5:0] IDX_POLICE_CH2  = 6'h1f;  // Policing limit, channel 2.
  localparam logic [5:0] IDX_POLICE_CH3  = 6'h20;  // Policing limit, channel 3.
  localparam logic [5:0] IDX_POLICE_CH4  = 6'h21;  // Policing limit, channel 4.
  localparam logic [5:0] IDX_CAP_ENABLE  = 6'h22;  // Legacy capacitance detection enables.
  localparam logic [5:0] IDX_FAULT       = 6'h24;  // Turn-on fault status, plain read.
  localparam logic [5:0] IDX_FAULT_CLEAR = 6'h25;  // Turn-on fault status, clear on read.
  localparam logic [5:0] IDX_CHAN_CTRL   = 6'h30;  // Override select [3:0] and diagnostic mode [7:4].
  localparam logic [5:0] IDX_DISC_START  = 6'h31;  // Discovery start strobes [3:0], write only.
  localparam logic [5:0] IDX_DISC_DONE   = 6'h32;  // Discovery done events [3:0], write one to clear.

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset and field masks.
  localparam logic [7:0] POLICE_RESET   = 8'hff;  // Policing limit after reset or turn-off.
  localparam logic [7:0] CAP_RESET      = 8'h00;  // All capacitance measurements disabled.
  localparam logic [7:0] FAULT_RESET    = 8'h00;  // No turn-on fault recorded.
  localparam logic [7:0] CAP_FIELD_MASK = 8'h55;  // Only even bits carry enables.

  // Policing step and floor, in milliwatts, and the floor as a register code.
  localparam int unsigned POLICING_STEP_MW = 500;
  localparam int unsigned POLICING_FLOOR_MW = 2000;
  localparam logic [7:0] POLICE_FLOOR = 8'(POLICING_FLOOR_MW / POLICING_STEP_MW);

  // Policing codes loaded at turn-on from the assigned class (class 1 to 4 as 0 to 3).
  localparam logic [7:0] POLICE_CLASS1 = 8'h08;
  localparam logic [7:0] POLICE_CLASS2 = 8'h0e;
  localparam logic [7:0] POLICE_CLASS3 = 8'h1f;
  localparam logic [7:0] POLICE_CLASS4 = 8'h3c;

  // Turn-on fault codes.
  localparam logic [1:0] FAULT_NONE      = 2'h0;
  localparam logic [1:0] FAULT_DETECT    = 2'h1;
  localparam logic [1:0] FAULT_CLASS     = 2'h2;
  localparam logic [1:0] FAULT_NO_POWER  = 2'h3;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Whole state of the bank, registered as one word.
  typedef struct packed {
    logic [2:0][7:0] lim;        // Policing limits, channels 2 to 4.
    logic [2:0][7:0] eff;        // Effective limits after the floor.
    logic [2:0]      trip;       // Power cut fault flags.
    logic [7:0]      cap_en;     // Capacitance enable register.
    logic [7:0]      fault;      // Turn-on fault codes, two bits per channel.
    logic [3:0]      ovr;        // Override policing select per channel.
    logic [3:0]      diag;       // Manual or diagnostic mode per channel.
    logic [3:0]      done_evt;   // Discovery done events.
    logic [3:0]      pend;       // Capacitance step waiting for resistance result.
    logic [3:0]      run;        // Capacitance measurement running.
    logic [3:0]      det_start;  // Detection start pulses.
    logic [3:0]      cap_start;  // Capacitance measurement start pulses.
    logic [3:0]      res_upd;    // Result update pulses.
    logic            aw_full;    // Write address held.
    logic [7:0]      awaddr;     // Held write address.
    logic            w_full;     // Write data held.
    logic [7:0]      wdata;      // Held write data, low byte.
    logic            wbyte;      // Low byte lane enabled.
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [7:0]      rdata;
    logic [1:0]      rresp;
  } ppcfr_state_t;

  // Class code to policing code.
  function automatic logic [7:0] ppcfr_class_code(input logic [1:0] cls);
    case (cls)
      2'h0:    ppcfr_class_code = POLICE_CLASS1;
      2'h1:    ppcfr_class_code = POLICE_CLASS2;
      2'h2:    ppcfr_class_code = POLICE_CLASS3;
      default: ppcfr_class_code = POLICE_CLASS4;
    endcase
  endfunction

endpackage

/* verilog/ppcfr_regs.sv */
// Policing limit, capacitance detection and turn-on fault register bank with an AXI4-Lite slave.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module ppcfr_regs #(
  parameter logic [15:0] POWER_PER_STEP = 16'h0020,  // Power product units in one policing step.
  parameter logic [15:0] TRIP_MARGIN    = 16'h0004   // Product units added above the minimum.
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RESET,
  input  wire logic [7:0]       AWADDR,
  input  wire logic             AWVALID,
  output logic                  AWREADY,
  input  wire logic [31:0]      WDATA,
  input  wire logic [3:0]       WSTRB,
  input  wire logic             WVALID,
  output logic                  WREADY,
  output logic [1:0]            BRESP,
  output logic                  BVALID,
  input  wire logic             BREADY,
  input  wire logic [7:0]       ARADDR,
  input  wire logic             ARVALID,
  output logic                  ARREADY,
  output logic [31:0]           RDATA,
  output logic [1:0]            RRESP,
  output logic                  RVALID,
  input  wire logic             RREADY,
  input  wire logic [3:0]       PORT_OFF,
  input  wire logic [3:0]       CHAN_RESET,
  input  wire logic [3:0]       POWER_ON_LOAD,
  input  wire logic [2:0][1:0]  ASSIGNED_CLASS,
  input  wire logic [2:0][7:0]  PORT_VOLTAGE,
  input  wire logic [2:0][7:0]  PORT_CURRENT,
  input  wire logic [3:0]       START_FAULT,
  input  wire logic [3:0][1:0]  FAULT_CAUSE,
  input  wire logic [3:0]       POWER_ENABLE_CHANGE_EVENT,
  input  wire logic [3:0]       ALLOC_DENY,
  input  wire logic [3:0]       RES_DET_DONE,
  input  wire logic [3:0]       RES_DET_VALID,
  input  wire logic [3:0]       CAP_MEAS_DONE,
  output logic [2:0][7:0]       EFF_LIMIT,
  output logic [2:0]            POWER_CUT_FAULT,
  output logic [3:0]            DET_START,
  output logic [3:0]            CAP_MEAS_START,
  output logic [3:0]            RESULT_UPDATE,
  output logic [3:0]            DISCOVERY_DONE
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and its next value.
  ppcfr_pkg::ppcfr_state_t s;       // Registered state.
  ppcfr_pkg::ppcfr_state_t next_s;  // Value for the next edge.

  // Returns one when the index names a register of the bank.
  function automatic logic reg_hit(input logic [5:0] idx);
    if (idx == ppcfr_pkg::IDX_POLICE_CH2 || idx == ppcfr_pkg::IDX_POLICE_CH3) begin
      reg_hit = 1'b1;
    end else if (idx == ppcfr_pkg::IDX_POLICE_CH4 || idx == ppcfr_pkg::IDX_CAP_ENABLE) begin
      reg_hit = 1'b1;
    end else if (idx == ppcfr_pkg::IDX_FAULT || idx == ppcfr_pkg::IDX_FAULT_CLEAR) begin
      reg_hit = 1'b1;
    end else if (idx == ppcfr_pkg::IDX_CHAN_CTRL || idx == ppcfr_pkg::IDX_DISC_START) begin
      reg_hit = 1'b1;
    end else begin
      reg_hit = (idx == ppcfr_pkg::IDX_DISC_DONE);
    end
  endfunction

  // Read value of a register; unused and reserved bits read as zero.
  function automatic logic [7:0] reg_value(input ppcfr_pkg::ppcfr_state_t st, input logic [5:0] idx);
    if (idx == ppcfr_pkg::IDX_POLICE_CH2) begin
      reg_value = st.lim[0];
    end else if (idx == ppcfr_pkg::IDX_POLICE_CH3) begin
      reg_value = st.lim[1];
    end else if (idx == ppcfr_pkg::IDX_POLICE_CH4) begin
      reg_value = st.lim[2];
    end else if (idx == ppcfr_pkg::IDX_CAP_ENABLE) begin
      reg_value = st.cap_en;
    end else if (idx == ppcfr_pkg::IDX_FAULT || idx == ppcfr_pkg::IDX_FAULT_CLEAR) begin
      reg_value = st.fault;
    end else if (idx == ppcfr_pkg::IDX_CHAN_CTRL) begin
      reg_value = {st.diag, st.ovr};
    end else if (idx == ppcfr_pkg::IDX_DISC_DONE) begin
      reg_value = {4'h0, st.done_evt};
    end else begin
      reg_value = 8'h00;
    end
  endfunction

  // Trip level in product units: the minimum plus a margin, so the minimum itself never trips.
  function automatic logic [23:0] trip_level(input logic [7:0] eff);
    trip_level = 24'(eff) * 24'(POWER_PER_STEP) + 24'(TRIP_MARGIN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus first, then hardware events, so hardware sets win over software clears.
  always_comb begin
    logic       wr_go;
    logic       rd_go;
    logic       clr_fault;
    logic [5:0] widx;
    logic [5:0] ridx;
    logic [15:0] pw;
    wr_go     = 1'b0;
    rd_go     = 1'b0;
    clr_fault = 1'b0;
    widx      = s.awaddr[7:2];
    ridx      = ARADDR[7:2];
    pw        = 16'h0000;
    next_s    = s;
    // Pulse outputs last one cycle.
    next_s.det_start = 4'h0;
    next_s.cap_start = 4'h0;
    next_s.res_upd   = 4'h0;

    // Address and data are taken independently, in either order.
    if (AWVALID && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr  = AWADDR;
    end
    if (WVALID && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = WDATA[7:0];
      next_s.wbyte  = WSTRB[0];
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    wr_go = s.aw_full && s.w_full && !s.bvalid;

    // Register writes; a write with the low lane off changes nothing.
    if (wr_go) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = reg_hit(widx) ? ppcfr_pkg::RESP_OKAY : ppcfr_pkg::RESP_SLVERR;
      if (s.wbyte) begin
        if (widx == ppcfr_pkg::IDX_POLICE_CH2) begin
          next_s.lim[0] = s.wdata;
        end else if (widx == ppcfr_pkg::IDX_POLICE_CH3) begin
          next_s.lim[1] = s.wdata;
        end else if (widx == ppcfr_pkg::IDX_POLICE_CH4) begin
          next_s.lim[2] = s.wdata;
        end else if (widx == ppcfr_pkg::IDX_CAP_ENABLE) begin
          next_s.cap_en = s.wdata & ppcfr_pkg::CAP_FIELD_MASK;
        end else if (widx == ppcfr_pkg::IDX_CHAN_CTRL) begin
          next_s.ovr  = s.wdata[3:0];
          next_s.diag = s.wdata[7:4];
        end else if (widx == ppcfr_pkg::IDX_DISC_START) begin
          for (int c = 0; c < 4; c++) begin
            if (s.wdata[c]) begin
              next_s.det_start[c] = 1'b1;
              // Capacitance step is armed only in diagnostic mode with its enable set.
              next_s.pend[c] = s.cap_en[2*c] && s.diag[c];
              next_s.run[c]  = 1'b0;
            end
          end
        end else if (widx == ppcfr_pkg::IDX_DISC_DONE) begin
          next_s.done_evt = s.done_evt & ~s.wdata[3:0];
        end
      end
    end

    // Reads: one at a time, answered on the next edge.
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    rd_go = ARVALID && s.arready;
    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = reg_value(s, ridx);
      next_s.rresp  = reg_hit(ridx) ? ppcfr_pkg::RESP_OKAY : ppcfr_pkg::RESP_SLVERR;
      clr_fault     = (ridx == ppcfr_pkg::IDX_FAULT_CLEAR);
    end

    // Turn-on fault codes: clears first, recorded causes after, so a new fault survives.
    if (clr_fault) begin
      next_s.fault = ppcfr_pkg::FAULT_RESET;
    end
    for (int c = 0; c < 4; c++) begin
      if (PORT_OFF[c] || CHAN_RESET[c]) begin
        next_s.fault[2*c +: 2] = ppcfr_pkg::FAULT_NONE;
      end
      if (START_FAULT[c] && !POWER_ENABLE_CHANGE_EVENT[c]) begin
        // Allocation denial overrides whatever the core reports as cause.
        next_s.fault[2*c +: 2] = ALLOC_DENY[c] ? ppcfr_pkg::FAULT_NO_POWER : FAULT_CAUSE[c];
      end
    end

    // Capacitance sequencing per channel; turn-off aborts it.
    for (int c = 0; c < 4; c++) begin
      if (RES_DET_DONE[c]) begin
        if (s.pend[c] && !RES_DET_VALID[c]) begin
          next_s.pend[c]      = 1'b0;
          next_s.run[c]       = 1'b1;
          next_s.cap_start[c] = 1'b1;
        end else begin
          // Valid signature or no step armed: no capacitance step, discovery is done now.
          next_s.pend[c]     = 1'b0;
          next_s.done_evt[c] = 1'b1;
        end
      end
      if (CAP_MEAS_DONE[c] && s.run[c]) begin
        next_s.run[c]      = 1'b0;
        next_s.done_evt[c] = 1'b1;
        next_s.res_upd[c]  = 1'b1;
      end
      if (PORT_OFF[c] || CHAN_RESET[c]) begin
        next_s.pend[c] = 1'b0;
        next_s.run[c]  = 1'b0;
      end
    end

    // Policing channels 2 to 4: load at turn-on, then turn-off overrides everything.
    for (int p = 0; p < 3; p++) begin
      // Loading only on the turn-on pulse lets later software writes stick.
      if (POWER_ON_LOAD[p+1] && !s.diag[p+1] && !s.ovr[p+1]) begin
        next_s.lim[p] = ppcfr_pkg::ppcfr_class_code(ASSIGNED_CLASS[p]);
      end
      if (PORT_OFF[p+1] || CHAN_RESET[p+1]) begin
        next_s.lim[p] = ppcfr_pkg::POLICE_RESET;
      end
      // Floor the code at two watts.
      next_s.eff[p] = (s.lim[p] < ppcfr_pkg::POLICE_FLOOR) ? ppcfr_pkg::POLICE_FLOOR : s.lim[p];
      // True power: voltage times current, so supply droop is accounted for.
      pw = {8'h00, PORT_VOLTAGE[p]} * {8'h00, PORT_CURRENT[p]};
      next_s.trip[p] = ({8'h00, pw} > trip_level(s.eff[p]));
    end

    // Ready lines close while a transfer is held or its answer is waiting.
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready  = !next_s.w_full && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      s         <= '0;
      s.lim     <= {3{ppcfr_pkg::POLICE_RESET}};
      s.eff     <= {3{ppcfr_pkg::POLICE_RESET}};
      s.cap_en  <= ppcfr_pkg::CAP_RESET;
      s.fault   <= ppcfr_pkg::FAULT_RESET;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign AWREADY         = s.awready;
  assign WREADY          = s.wready;
  assign BVALID          = s.bvalid;
  assign BRESP           = s.bresp;
  assign ARREADY         = s.arready;
  assign RVALID          = s.rvalid;
  assign RDATA           = {24'h000000, s.rdata};
  assign RRESP           = s.rresp;
  assign EFF_LIMIT       = s.eff;
  assign POWER_CUT_FAULT = s.trip;
  assign DET_START       = s.det_start;
  assign CAP_MEAS_START  = s.cap_start;
  assign RESULT_UPDATE   = s.res_upd;
  assign DISCOVERY_DONE  = s.done_evt;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on channel 2 (policing slot 0, event slot 1), channel 3 (policing slot 1) and channel 1 (event slot 0).
  sequence s_cap_begin;
    RES_DET_DONE[1] && s.pend[1] && !RES_DET_VALID[1] && !PORT_OFF[1] && !CHAN_RESET[1] ##1 CAP_MEAS_START[1];
  endsequence

  sequence s_clear_read;
    ARVALID && ARREADY && (ARADDR[7:2] == ppcfr_pkg::IDX_FAULT_CLEAR) && (START_FAULT == 4'h0);
  endsequence

  a_off_restore: assert property (@(posedge CORE_CLK) disable iff (RESET)
    PORT_OFF[1] |=> (s.lim[0] == ppcfr_pkg::POLICE_RESET) ##1 (EFF_LIMIT[0] == ppcfr_pkg::POLICE_RESET))
    else $error("policing limit not restored after port off");

  a_floor_clamp: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !$past(RESET) |-> EFF_LIMIT[0] == (($past(s.lim[0]) < 8'h04) ? 8'h04 : $past(s.lim[0])))
    else $error("effective limit differs from floored code");

  a_class_load: assert property (@(posedge CORE_CLK) disable iff (RESET)
    POWER_ON_LOAD[2] && ASSIGNED_CLASS[1] == 2'h3 && !s.diag[2] && !s.ovr[2] && !PORT_OFF[2] && !CHAN_RESET[2]
      |=> s.lim[1] == 8'h3c)
    else $error("class four did not load its policing code");

  a_fault_record: assert property (@(posedge CORE_CLK) disable iff (RESET)
    START_FAULT[0] && !POWER_ENABLE_CHANGE_EVENT[0]
      |=> s.fault[1:0] == ($past(ALLOC_DENY[0]) ? 2'h3 : $past(FAULT_CAUSE[0])))
    else $error("start fault cause not recorded");

  a_fault_off: assert property (@(posedge CORE_CLK) disable iff (RESET)
    PORT_OFF[1] && !START_FAULT[1] |=> s.fault[3:2] == 2'h0)
    else $error("fault code survived turn-off");

  a_read_clear: assert property (@(posedge CORE_CLK) disable iff (RESET)
    s_clear_read |=> RVALID && RDATA[7:0] == $past(s.fault) && s.fault == 8'h00)
    else $error("clear-on-read did not return and clear status");

  a_cap_skip: assert property (@(posedge CORE_CLK) disable iff (RESET)
    RES_DET_DONE[1] && RES_DET_VALID[1] |=> !CAP_MEAS_START[1] && DISCOVERY_DONE[1])
    else $error("capacitance measured after valid detection");

  a_cap_diag: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(s.pend[1]) |-> $past(s.diag[1]) && $past(s.cap_en[2]))
    else $error("capacitance armed outside diagnostic mode");

  a_cap_done: assert property (@(posedge CORE_CLK) disable iff (RESET)
    s_cap_begin ##[1:1000] (CAP_MEAS_DONE[1] && s.run[1])
      |=> RESULT_UPDATE[1] && DISCOVERY_DONE[1])
    else $error("finished measurement not flagged");

  a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ##1 (s.cap_en & 8'haa) == 8'h00 [*2])
    else $error("reserved capacitance bits set");

endmodule
